// ---- logic/tmspi_pkg.sv ----
// Shared constants and types of the temperature device's serial host port.
// Assumes a 25 MHz system clock; the serial clock comes from the host.
package tmspi_pkg;

    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;

    // Start-up phases, longest times in milliseconds, rounded down to cycles
    localparam int unsigned ANALOG_UP_MS    = 100;
    localparam int unsigned DIGITAL_INIT_MS = 100;
    localparam int unsigned ANALOG_UP_CYC   = ANALOG_UP_MS * CLK_PER_MS;
    localparam int unsigned DIGITAL_INIT_CYC = DIGITAL_INIT_MS * CLK_PER_MS;

    // Highest serial clock rate the host may use
    localparam int unsigned SCK_MAX_HZ      = 2_000_000;

    localparam int unsigned WORD_W          = 8;
    localparam int unsigned BIT_IDX_W       = 3;
    localparam logic [2:0]  BIT_LAST        = 3'h7;

    // Command status byte values
    localparam logic [7:0]  STAT_HIDDEN     = 8'h00;
    localparam logic [7:0]  STAT_INIT_BEGIN = 8'h80;
    localparam logic [7:0]  STAT_INIT_DONE  = 8'h40;
    localparam logic [7:0]  STAT_CONV_BUSY  = 8'h80;

    // Multiplexer configuration delay, in microseconds
    localparam int unsigned MUX_DELAY_W     = 16;
    localparam logic [15:0] MUX_DELAY_RST   = 16'h03e8;

    typedef enum logic [1:0] {
        TMSPI_REJ_50_60,
        TMSPI_REJ_60,
        TMSPI_REJ_50
    } tmspi_rej_t;

    localparam tmspi_rej_t  REJ_RST         = TMSPI_REJ_50_60;

    typedef enum logic [2:0] {
        TMSPI_ST_ANALOG,
        TMSPI_ST_DIGITAL,
        TMSPI_ST_IDLE,
        TMSPI_ST_CONV
    } tmspi_state_t;

endpackage

// ---- logic/tmspi_buf2.sv ----
// Small valid/ready buffer, two entries by default.
// Assumes both sides run on the same clock.
`timescale 1ns/10ps
module tmspi_buf2 #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
            $error("tmspi_buf2: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0]   count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (PTR_W+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clock)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= in_data;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// ---- logic/tmspi_host_port.sv ----
// Serial host port and start-up sequencer of the temperature device.
// Assumes sck, cs_n and sdi come straight from pins, the host drives sck low
// while deselected, and a measurement core on clock reports conversions.
//
// Function
// - The serial output bit changes on each falling edge of the serial clock.
// - The serial input bit is captured on each rising edge of the serial clock.
// - The serial output is released whenever chip select is high.
// - Chip select falling opens a transaction, rising closes it, and the serial logic works only in between.
// - During a transaction the serial output shifts out the requested data bytes; here byte 0 is the status byte, then queued tx bytes (status again when empty).
// - Busy/done stays low during start-up and during a conversion.
// - Busy/done goes high when start-up ends or when a conversion completes.
// - While reset is low the device stays in its reset state.
// - After reset rises the device runs analog power-up and then digital initialization.
// - The command status value is not available to the host during analog power-up.
// - Digital initialization starts right after analog power-up ends.
// - Command status reads one value as initialization begins and another once it is complete.
// - The multiplexer configuration delay defaults to one millisecond after reset.
// - The global configuration defaults to rejection of both mains frequencies after reset.
`timescale 1ns/10ps
module tmspi_host_port
#(
    parameter int unsigned ANALOG_CYCLES  = tmspi_pkg::ANALOG_UP_CYC,
    parameter int unsigned DIGITAL_CYCLES = tmspi_pkg::DIGITAL_INIT_CYC,
    parameter int unsigned BUF_DEPTH      = 2
) (
    input  wire logic                                clock,
    input  wire logic                                rstn,
    input  wire logic                                sck,
    input  wire logic                                cs_n,
    input  wire logic                                sdi,
    output logic                                     sdo_out,
    output logic                                     sdo_oe,
    output logic                                     busy_done,
    input  wire logic                                conv_start,
    input  wire logic                                conv_done,
    output logic                                     rx_valid,
    input  wire logic                                rx_ready,
    output logic      [tmspi_pkg::WORD_W-1:0]        rx_data,
    output logic                                     rx_overrun,
    input  wire logic                                tx_valid,
    output logic                                     tx_ready,
    input  wire logic [tmspi_pkg::WORD_W-1:0]        tx_data,
    input  wire logic                                cfg_wr,
    input  wire logic [tmspi_pkg::MUX_DELAY_W-1:0]   cfg_mux_delay,
    input  wire tmspi_pkg::tmspi_rej_t               cfg_reject,
    output logic      [tmspi_pkg::MUX_DELAY_W-1:0]   mux_delay,
    output tmspi_pkg::tmspi_rej_t                    reject_mode,
    output logic      [tmspi_pkg::WORD_W-1:0]        cmd_status
);
    import tmspi_pkg::*;

    localparam int unsigned MAX_CYC = (ANALOG_CYCLES > DIGITAL_CYCLES) ? ANALOG_CYCLES : DIGITAL_CYCLES;
    localparam int unsigned TMR_W   = $clog2(MAX_CYC + 1);

    initial
    begin
        if (ANALOG_CYCLES < 1 || DIGITAL_CYCLES < 1)
            $error("tmspi_host_port: start-up phase counts must be at least one cycle");
        if (BUF_DEPTH < 2)
            $error("tmspi_host_port: BUF_DEPTH must be at least 2");
    end

    // Link side, clocked by sck
    // Bit counters restart at every chip select; word and toggle registers
    // survive deselection so the toggle crossing never sees a false event.
    logic                 frame_rstn;
    logic [BIT_IDX_W-1:0] rx_bit_reg;
    logic [WORD_W-2:0]    rx_shift_reg;
    logic [WORD_W-1:0]    rx_word_reg;
    logic                 rx_tgl_reg;
    logic [BIT_IDX_W-1:0] tx_idx_reg;
    logic                 tx_first_reg;
    logic [WORD_W-1:0]    tx_cur_reg;
    logic                 tx_tgl_reg;

    // Clock side registers read by the link logic
    logic [WORD_W-1:0]    stat_hold_reg;
    logic [WORD_W-1:0]    tx_hold_reg;

    assign frame_rstn = rstn & ~cs_n;

    always_ff @(posedge sck or negedge frame_rstn)
    begin
        if (!frame_rstn)
        begin
            rx_bit_reg   <= '0;
            rx_shift_reg <= '0;
        end
        else
        begin
            rx_bit_reg   <= rx_bit_reg + 1'b1;
            rx_shift_reg <= {rx_shift_reg[WORD_W-3:0], sdi};
        end
    end

    always_ff @(posedge sck or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_word_reg <= '0;
            rx_tgl_reg  <= 1'b0;
        end
        else if (!cs_n && rx_bit_reg == BIT_LAST)
        begin
            rx_word_reg <= {rx_shift_reg, sdi};
            rx_tgl_reg  <= ~rx_tgl_reg;
        end
    end

    always_ff @(negedge sck or negedge frame_rstn)
    begin
        if (!frame_rstn)
        begin
            tx_idx_reg   <= '0;
            tx_first_reg <= 1'b1;
        end
        else
        begin
            tx_idx_reg <= tx_idx_reg + 1'b1;
            if (tx_idx_reg == BIT_LAST)
                tx_first_reg <= 1'b0;
        end
    end

    // The next byte was prepared by the clock side within three clock cycles of the previous load or of chip select falling
    always_ff @(negedge sck or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_cur_reg <= '0;
            tx_tgl_reg <= 1'b0;
        end
        else if (!cs_n && tx_idx_reg == BIT_LAST)
        begin
            tx_cur_reg <= tx_hold_reg;
            tx_tgl_reg <= ~tx_tgl_reg;
        end
    end

    // First bit must stand before any sck edge, so byte 0 comes straight from the status hold
    always_comb
    begin
        if (tx_first_reg)
            sdo_out = stat_hold_reg[BIT_LAST - tx_idx_reg];
        else
            sdo_out = tx_cur_reg[BIT_LAST - tx_idx_reg];
    end

    assign sdo_oe = ~cs_n & rstn;

    // Crossings into the clock domain
    logic cs_sync1_reg;
    logic cs_sync2_reg;
    logic cs_seen_reg;
    logic rx_sync1_reg;
    logic rx_sync2_reg;
    logic rx_seen_reg;
    logic tx_sync1_reg;
    logic tx_sync2_reg;
    logic tx_seen_reg;
    logic rx_evt;
    logic tx_evt;
    logic cs_fall_evt;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cs_sync1_reg <= 1'b1;
            cs_sync2_reg <= 1'b1;
            cs_seen_reg  <= 1'b1;
            rx_sync1_reg <= 1'b0;
            rx_sync2_reg <= 1'b0;
            rx_seen_reg  <= 1'b0;
            tx_sync1_reg <= 1'b0;
            tx_sync2_reg <= 1'b0;
            tx_seen_reg  <= 1'b0;
        end
        else
        begin
            cs_sync1_reg <= cs_n;
            cs_sync2_reg <= cs_sync1_reg;
            cs_seen_reg  <= cs_sync2_reg;
            rx_sync1_reg <= rx_tgl_reg;
            rx_sync2_reg <= rx_sync1_reg;
            rx_seen_reg  <= rx_sync2_reg;
            tx_sync1_reg <= tx_tgl_reg;
            tx_sync2_reg <= tx_sync1_reg;
            tx_seen_reg  <= tx_sync2_reg;
        end
    end

    assign rx_evt      = rx_sync2_reg ^ rx_seen_reg;
    assign tx_evt      = tx_sync2_reg ^ tx_seen_reg;
    assign cs_fall_evt = cs_seen_reg & ~cs_sync2_reg;

    // Start-up sequencer and busy/done
    tmspi_state_t     state_reg;
    logic [TMR_W-1:0] timer_reg;
    logic             phase_end;

    always_comb
    begin
        phase_end = 1'b0;
        unique case (state_reg)
            TMSPI_ST_ANALOG:  phase_end = (timer_reg == TMR_W'(ANALOG_CYCLES - 1));
            TMSPI_ST_DIGITAL: phase_end = (timer_reg == TMR_W'(DIGITAL_CYCLES - 1));
            TMSPI_ST_IDLE:    phase_end = 1'b0;
            TMSPI_ST_CONV:    phase_end = 1'b0;
            default:          phase_end = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            timer_reg <= '0;
        else if (phase_end)
            timer_reg <= '0;
        else if (state_reg == TMSPI_ST_ANALOG || state_reg == TMSPI_ST_DIGITAL)
            timer_reg <= timer_reg + 1'b1;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            state_reg <= TMSPI_ST_ANALOG;
        else
        begin
            unique case (state_reg)
                TMSPI_ST_ANALOG:
                    if (phase_end)
                        state_reg <= TMSPI_ST_DIGITAL;
                TMSPI_ST_DIGITAL:
                    if (phase_end)
                        state_reg <= TMSPI_ST_IDLE;
                TMSPI_ST_IDLE:
                    if (conv_start && !conv_done)
                        state_reg <= TMSPI_ST_CONV;
                TMSPI_ST_CONV:
                    if (conv_done)
                        state_reg <= TMSPI_ST_IDLE;
                default:
                    state_reg <= TMSPI_ST_ANALOG;
            endcase
        end
    end

    // Registered, so it trails the state by one cycle at start-up end; on conversion start and end it changes with the state
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            busy_done <= 1'b0;
        else if (state_reg == TMSPI_ST_IDLE && !(conv_start && !conv_done))
            busy_done <= 1'b1;
        else if (state_reg == TMSPI_ST_CONV && conv_done)
            busy_done <= 1'b1;
        else
            busy_done <= 1'b0;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            cmd_status <= STAT_HIDDEN;
        else
        begin
            unique case (state_reg)
                TMSPI_ST_ANALOG:  cmd_status <= STAT_HIDDEN;
                TMSPI_ST_DIGITAL: cmd_status <= STAT_INIT_BEGIN;
                TMSPI_ST_IDLE:    cmd_status <= STAT_INIT_DONE;
                TMSPI_ST_CONV:    cmd_status <= STAT_CONV_BUSY;
                default:          cmd_status <= STAT_HIDDEN;
            endcase
        end
    end

    // Frozen while selected, so the link side reads it unsynchronised; it may still move
    // for two cycles after chip select falls, well before the host samples the first bit.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            stat_hold_reg <= STAT_HIDDEN;
        else if (cs_sync2_reg)
            stat_hold_reg <= cmd_status;
    end

    // Configuration defaults
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            mux_delay   <= MUX_DELAY_RST;
            reject_mode <= REJ_RST;
        end
        else if (cfg_wr)
        begin
            mux_delay   <= cfg_mux_delay;
            reject_mode <= cfg_reject;
        end
    end

    // Data paths through BUF_DEPTH-entry buffers, two entries by default
    logic              rx_in_ready;
    logic              txq_valid;
    logic              txq_pop;
    logic [WORD_W-1:0] txq_data;

    tmspi_buf2 #(
        .WIDTH (WORD_W),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .clock     (clock),
        .rstn      (rstn),
        .in_valid  (rx_evt),
        .in_ready  (rx_in_ready),
        .in_data   (rx_word_reg),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // A received byte has nowhere to wait, so a full buffer is reported
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rx_overrun <= 1'b0;
        else
            rx_overrun <= rx_evt & ~rx_in_ready;
    end

    tmspi_buf2 #(
        .WIDTH (WORD_W),
        .DEPTH (BUF_DEPTH)
    ) u_tx_buf (
        .clock     (clock),
        .rstn      (rstn),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (txq_valid),
        .out_ready (txq_pop),
        .out_data  (txq_data)
    );

    // Refilled at chip select and after each byte the link side takes over;
    // an empty queue repeats the status byte rather than stalling the host.
    assign txq_pop = (cs_fall_evt | tx_evt) & txq_valid;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            tx_hold_reg <= STAT_HIDDEN;
        else if (cs_fall_evt || tx_evt)
        begin
            if (txq_valid)
                tx_hold_reg <= txq_data;
            else
                tx_hold_reg <= cmd_status;
        end
    end

endmodule

// ---- verif/tmspi_host_port_asserts.sv ----
// Checker for the host port: start-up sequence, busy flag, config and rx buffer.
// Assumes it is bound into tmspi_host_port and handed the same start-up counts.
`timescale 1ns/10ps
module tmspi_host_port_asserts
#(
    parameter int unsigned ANALOG_CYCLES  = 20,
    parameter int unsigned DIGITAL_CYCLES = 30
) (
    input wire logic                              clock,
    input wire logic                              rstn,
    input wire logic                              cs_n,
    input wire logic                              sdo_oe,
    input wire logic                              busy_done,
    input wire logic                              conv_start,
    input wire logic                              conv_done,
    input wire logic                              rx_valid,
    input wire logic                              rx_ready,
    input wire logic [tmspi_pkg::WORD_W-1:0]      rx_data,
    input wire logic                              rx_overrun,
    input wire logic                              cfg_wr,
    input wire logic [tmspi_pkg::MUX_DELAY_W-1:0] cfg_mux_delay,
    input wire tmspi_pkg::tmspi_rej_t             cfg_reject,
    input wire logic [tmspi_pkg::MUX_DELAY_W-1:0] mux_delay,
    input wire tmspi_pkg::tmspi_rej_t             reject_mode,
    input wire logic [tmspi_pkg::WORD_W-1:0]      cmd_status
);
    import tmspi_pkg::*;
    localparam int unsigned T_DIG  = ANALOG_CYCLES + 3;
    localparam int unsigned T_IDLE = ANALOG_CYCLES + DIGITAL_CYCLES + 3;
    logic [31:0] up_cnt_reg;
    // Saturates past the idle point so later conversions never meet the start-up checks
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            up_cnt_reg <= 32'h0;
        else if (up_cnt_reg <= T_IDLE)
            up_cnt_reg <= up_cnt_reg + 32'h1;
    end
    wire ready_w = (up_cnt_reg > T_IDLE);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_oe_cs; sdo_oe == !cs_n; endproperty
    property p_rst_vals;
        $rose(rstn) |-> !busy_done && cmd_status == STAT_HIDDEN && mux_delay == MUX_DELAY_RST && reject_mode == REJ_RST;
    endproperty
    property p_hidden; up_cnt_reg < ANALOG_CYCLES |-> cmd_status == STAT_HIDDEN && !busy_done; endproperty
    property p_dig; up_cnt_reg == T_DIG |-> cmd_status == STAT_INIT_BEGIN && !busy_done; endproperty
    property p_idle; up_cnt_reg == T_IDLE |-> busy_done && cmd_status == STAT_INIT_DONE; endproperty
    property p_conv_go;
        ready_w && busy_done && conv_start && !conv_done |-> ##[1:3] (!busy_done && cmd_status == STAT_CONV_BUSY);
    endproperty
    property p_conv_end; ready_w && !busy_done && conv_done |-> ##[1:3] (busy_done && cmd_status == STAT_INIT_DONE);
    endproperty
    property p_conv_hold; (!conv_done)[*3] ##1 (ready_w && !busy_done && !conv_done) |=> !busy_done; endproperty
    property p_cfg; cfg_wr |=> mux_delay == $past(cfg_mux_delay) && reject_mode == $past(cfg_reject); endproperty
    property p_cfg_keep; !cfg_wr |=> $stable(mux_delay) && $stable(reject_mode); endproperty
    property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty

    a_oe_cs: assert property (p_oe_cs) else $error("sdo enable differs from chip select");
    a_rst_vals: assert property (p_rst_vals) else $error("wrong values at reset release");
    a_hidden: assert property (p_hidden) else $error("status visible in analog power-up");
    a_dig: assert property (p_dig) else $error("digital init status missing");
    a_idle: assert property (p_idle) else $error("start-up did not finish on time");
    a_conv_go: assert property (p_conv_go) else $error("conversion did not show busy");
    a_conv_end: assert property (p_conv_end) else $error("conversion end not flagged");
    a_conv_hold: assert property (p_conv_hold) else $error("busy ended without conversion end");
    a_cfg: assert property (p_cfg) else $error("config write not taken");
    a_cfg_keep: assert property (p_cfg_keep) else $error("config changed without write");
    a_rx_hold: assert property (p_rx_hold) else $error("stalled rx byte changed");

    c_up: cover property (up_cnt_reg == T_IDLE && busy_done);
    c_conv: cover property (ready_w && busy_done && conv_start);
    c_ovr: cover property (rx_overrun);
    c_cfg: cover property (cfg_wr);
endmodule

bind tmspi_host_port tmspi_host_port_asserts #(.ANALOG_CYCLES(ANALOG_CYCLES), .DIGITAL_CYCLES(DIGITAL_CYCLES)) chk_u (
    .clock(clock), .rstn(rstn), .cs_n(cs_n), .sdo_oe(sdo_oe), .busy_done(busy_done), .conv_start(conv_start),
    .conv_done(conv_done), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun),
    .cfg_wr(cfg_wr), .cfg_mux_delay(cfg_mux_delay), .cfg_reject(cfg_reject), .mux_delay(mux_delay),
    .reject_mode(reject_mode), .cmd_status(cmd_status));

// ---- verif/tmspi_spi_host.sv ----
// Behavioural serial bus master standing in for the host controller.
// Assumes a free 32 ns base clock; the serial clock is made from it only within frames.
`timescale 1ns/10ps
module tmspi_spi_host (
    input  wire logic lclk,
    input  wire logic sdo,
    output logic      sck,
    output logic      cs_n,
    output logic      sdi
);
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // Eight base cycles is 256 ns, so each serial clock phase meets the 250 ns minimum
    task automatic half();
        repeat (8) @(posedge lclk);
    endtask
    task automatic xfer(input int n, input logic [7:0] mo [4], output logic [7:0] mi [4]);
        int b;
        int i;
        cs_n <= 1'b0;
        half();
        for (b = 0; b < n; b++)
            for (i = 7; i >= 0; i--)
            begin
                sdi <= mo[b][i];
                half();
                sck <= 1'b1;
                mi[b][i] = sdo;
                half();
                sck <= 1'b0;
            end
        half();
        cs_n <= 1'b1;
        sdi <= ~sdi;
        half();
    endtask
endmodule

// ---- verif/tmspi_host_port_tb_top.sv ----
// Self-checking bench for the host port: start-up, serial frames, buffers, conversions, config.
// Assumes the partner host model drives the serial pins; everything else is driven here.
`timescale 1ns/10ps
module tmspi_host_port_tb_top;
    import tmspi_pkg::*;
    localparam int unsigned AN = 200;
    localparam int unsigned DG = 300;
    logic       clock, rstn, lclk, conv_start, conv_done, rx_ready, tx_valid, cfg_wr, sdo_hold;
    logic       sck, cs_n, sdi, sdo_w, sdo_out, sdo_oe, busy_done, rx_valid, rx_overrun, tx_ready;
    logic [7:0] tx_data, rx_data, cmd_status;
    logic [7:0] mo [4];
    logic [7:0] mi [4];
    logic [7:0] ex [4];
    logic [15:0] cfg_mux_delay, mux_delay;
    tmspi_rej_t  cfg_reject, reject_mode;
    int          fail_count, n_checks, ovr_count, i;

    tmspi_host_port #(.ANALOG_CYCLES(AN), .DIGITAL_CYCLES(DG), .BUF_DEPTH(2)) dut_u (
        .clock(clock), .rstn(rstn), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .busy_done(busy_done), .conv_start(conv_start), .conv_done(conv_done), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .cfg_wr(cfg_wr), .cfg_mux_delay(cfg_mux_delay), .cfg_reject(cfg_reject),
        .mux_delay(mux_delay), .reject_mode(reject_mode), .cmd_status(cmd_status));
    tmspi_spi_host host_u (.lclk(lclk), .sdo(sdo_w), .sck(sck), .cs_n(cs_n), .sdi(sdi));

    // A released line shows the inverse of its last driven level, never a settled unknown
    always @(sdo_out or sdo_oe)
        if (sdo_oe === 1'b1)
            sdo_hold = sdo_out;
    assign sdo_w = (sdo_oe === 1'b1) ? sdo_out : ~sdo_hold;
    always @(posedge clock)
        if (rx_overrun === 1'b1)
            ovr_count++;
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial
    begin
        lclk = 1'b0;
        #7;
        forever #16 lclk = ~lclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    task automatic wait_status(input logic [7:0] st, input logic bd);
        int k;
        for (k = 0; k < 1000 && !(cmd_status === st && busy_done === bd); k++)
            @(negedge clock);
        chk("start_state", {7'h0, bd, st}, {7'h0, busy_done, cmd_status});
        if (k >= 1000)
            complete_run();
    endtask
    task automatic frame(input int n);
        int b;
        host_u.xfer(n, mo, mi);
        for (b = 0; b < n; b++)
            chk("sdo_byte", {8'h0, ex[b]}, {8'h0, mi[b]});
        repeat (6) @(negedge clock);
    endtask
    task automatic pop(input logic [7:0] exp);
        chk("rx_valid", 16'h1, {15'h0, rx_valid});
        chk("rx_data", {8'h0, exp}, {8'h0, rx_data});
        rx_ready = 1'b1;
        @(negedge clock);
        rx_ready = 1'b0;
        @(negedge clock);
    endtask
    task automatic t_reset_vals();
        cfg_wr = 1'b1;
        @(negedge clock);
        cfg_wr = 1'b0;
        chk("busy_done", 16'h0, {15'h0, busy_done});
        chk("cmd_status", {8'h0, STAT_HIDDEN}, {8'h0, cmd_status});
        chk("mux_delay", MUX_DELAY_RST, mux_delay);
        chk("reject_mode", {14'h0, REJ_RST}, {14'h0, reject_mode});
        chk("sdo_oe", 16'h0, {15'h0, sdo_oe});
        chk("buf_flags", 16'h1, {14'h0, rx_valid, tx_ready});
    endtask
    task automatic t_startup();
        mo[0] = 8'h96;
        ex[0] = STAT_HIDDEN;
        frame(1);
        chk("busy_done", 16'h0, {15'h0, busy_done});
        wait_status(STAT_INIT_BEGIN, 1'b0);
        wait_status(STAT_INIT_DONE, 1'b1);
        pop(8'h96);
    endtask
    task automatic t_cfg();
        for (i = 0; i < 3; i++)
        begin
            cfg_mux_delay = 16'h0100 + i[15:0];
            cfg_reject = tmspi_rej_t'(i);
            cfg_wr = 1'b1;
            @(negedge clock);
            cfg_wr = 1'b0;
            @(negedge clock);
            chk("mux_delay", 16'h0100 + i[15:0], mux_delay);
            chk("reject_mode", i[15:0], {14'h0, reject_mode});
        end
    endtask
    task automatic t_tx_rx();
        int ovr0;
        chk("tx_ready", 16'h1, {15'h0, tx_ready});
        tx_valid = 1'b1;
        tx_data = 8'hc3;
        @(negedge clock);
        tx_data = 8'h5a;
        @(negedge clock);
        tx_valid = 1'b0;
        chk("tx_ready", 16'h0, {15'h0, tx_ready});
        ovr0 = ovr_count;
        mo = '{8'ha5, 8'h3c, 8'h0f, 8'h81};
        ex = '{STAT_INIT_DONE, 8'hc3, 8'h5a, STAT_INIT_DONE};
        frame(4);
        chk("overruns", 16'h2, ovr_count[15:0] - ovr0[15:0]);
        pop(8'ha5);
        pop(8'h3c);
        chk("rx_empty", 16'h1, {14'h0, rx_valid, tx_ready});
        chk("sdo_oe", 16'h0, {15'h0, sdo_oe});
    endtask
    task automatic t_conv();
        conv_done = 1'b1;
        @(negedge clock);
        conv_done = 1'b0;
        repeat (3) @(negedge clock);
        chk("busy_done", 16'h1, {15'h0, busy_done});
        conv_start = 1'b1;
        @(negedge clock);
        conv_start = 1'b0;
        wait_status(STAT_CONV_BUSY, 1'b0);
        mo[0] = 8'h11;
        ex[0] = STAT_CONV_BUSY;
        frame(1);
        pop(8'h11);
        chk("busy_done", 16'h0, {15'h0, busy_done});
        conv_done = 1'b1;
        @(negedge clock);
        conv_done = 1'b0;
        wait_status(STAT_INIT_DONE, 1'b1);
    endtask

    initial
    begin
        {rstn, conv_start, conv_done, rx_ready, tx_valid, cfg_wr, sdo_hold} = 7'h0;
        {tx_data, cfg_mux_delay} = 24'h0;
        cfg_reject = TMSPI_REJ_60;
        {fail_count, n_checks, ovr_count} = {32'h0, 32'h0, 32'h0};
        @(negedge clock);
        t_reset_vals();
        rstn = 1'b1;
        t_startup();
        t_cfg();
        t_tx_rx();
        t_conv();
        rstn = 1'b0;
        t_reset_vals();
        rstn = 1'b1;
        wait_status(STAT_INIT_BEGIN, 1'b0);
        wait_status(STAT_INIT_DONE, 1'b1);
        complete_run();
    end
endmodule
